//--- design/adsp_pkg.sv
/*
 * Shared constants for the serial read and sleep port of a small
 * delta-sigma converter: timing counts, word layout and variant options.
 * Assumes a 20 MHz system clock on both ends of the link.
 */
//==============================================================================
// Operation
// (RQ1) Sclk high 200..2000 us enters sleep
// (RQ2) Sclk low 10 us leaves sleep
// (RQ3) Host bursts sclk at least 10 kHz
// (RQ4) Host parks sclk low when idle; the external-variant host keeps sclk running in idle
// (RQ5) Oscillator variant paces conversions near 64 kHz
// (RQ6) Oscillator variant: sclk only shifts and sleeps
// (RQ7) Oscillator variant accepts asynchronous sclk to 2 MHz
// (RQ8) External variant uses sclk as master clock
// (RQ9) External variant: 612 clocks per word
// (RQ10) Data pin driven only while select low
// (RQ11) Select low 200 ns before first rise
// (RQ12) No calibration; result passed untouched
// (RQ13) Result 16 or 20 bits, padded to 24
// (RQ14) Data pin low signals ready word
// (RQ15) 24 clocks; shift on fall, sample on rise
// (RQ16) Word: ready, overrange, oscillation, zero, result
// (RQ17) Pending word: rise 17 ticks early; discard; the code rises early only in the oscillator variant
// (RQ18) Sleep stops conversions; fresh words after wake
//==============================================================================
package adsp_pkg;
    localparam int CLK_KHZ = 20000;
    // Sleep entry window and wake hold, in microseconds.
    localparam int SLEEP_MIN_US = 200;
    localparam int SLEEP_MAX_US = 2000;
    localparam int WAKE_US = 10;
    // Least times round up to whole cycles.
    localparam int SLP_CYC = (SLEEP_MIN_US * CLK_KHZ + 999) / 1000;
    localparam int WAKE_CYC = (WAKE_US * CLK_KHZ + 999) / 1000;
    localparam int LVL_CNT_W = 12;
    // Internal oscillator, in kHz.
    localparam int OSC_MIN_KHZ = 32;
    localparam int OSC_NOM_KHZ = 64;
    localparam int OSC_MAX_KHZ = 100;
    localparam int OSC_DIV = CLK_KHZ / OSC_NOM_KHZ;
    localparam int OSC_DIV_W = 9;
    // Master clock ticks per conversion word and early warning ticks.
    localparam int CONV_TICKS = 612;
    localparam int CONV_CNT_W = 10;
    localparam int WARN_TICKS = 17;
    // Word layout.
    localparam int WORD_W = 24;
    localparam int FIELD_W = 20;
    localparam int BIT_OVR = 22;
    localparam int BIT_OSC = 21;
    localparam int BIT_CNT_W = 5;
    localparam int RES_W_DEF = 20;
    // Host timing: select setup 200 ns, serial half period.
    localparam int CS_SETUP_NS = 200;
    localparam int CS_SETUP_CYC = (CS_SETUP_NS * CLK_KHZ + 999999) / 1000000;
    localparam int HALF_CYC_DEF = 10;
    localparam int WAKE_HOLD_CYC = 2 * WAKE_CYC;
    localparam int TM_W = 16;
endpackage : adsp_pkg

//--- design/adsp_link_if.sv
/*
 * Three-wire link between the converter end and the host end.
 * Assumes a pull-up on the data line; the bench may add its own checks.
 */
`timescale 1ns/10ps
`default_nettype none
interface adsp_link_if;
    logic sclk;
    logic cs_n;
    logic sdo_out;
    logic sdo_oe_n;
    wire serial_data_out_pin;
    // Released line floats high through the pull-up.
    assign serial_data_out_pin = sdo_oe_n ? 1'b1 : sdo_out;
    modport dev (input sclk, input cs_n, output sdo_out, output sdo_oe_n);
    modport host (output sclk, output cs_n, input serial_data_out_pin);
endinterface : adsp_link_if
`default_nettype wire

//--- design/adsp_dev.sv
/*
 * Converter end: sleep control, conversion pacing and the 24-bit shift-out.
 * Assumes a modulator/filter delivers result and flags on sample_i and
 * friends, stable at the end of each conversion; the link pins are async.
 */
`timescale 1ns/10ps
`default_nettype none
module adsp_dev #(
    parameter bit EXT_CLK = 1'b0,
    parameter int RES_W = adsp_pkg::RES_W_DEF
) (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    adsp_link_if.dev link,
    input wire logic [RES_W-1:0] sample_i,
    input wire logic ovr_i,
    input wire logic osc_det_i,
    output logic asleep_o,
    output logic conv_done_o,
    output logic word_lost_o
);
    import adsp_pkg::*;

    //==========================================================================
    // Pin synchronisers
    //==========================================================================
    logic [1:0] sclk_s_q;
    logic [1:0] cs_s_q;
    logic sclk_d1_q;

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sclk_s_q <= 2'h0;
            cs_s_q <= 2'h3;
            sclk_d1_q <= 1'b0;
        end else begin
            sclk_s_q <= {sclk_s_q[0], link.sclk};
            cs_s_q <= {cs_s_q[0], link.cs_n};
            sclk_d1_q <= sclk_s_q[1];
        end
    end

    wire sclk_lvl = sclk_s_q[1];
    wire sclk_r = sclk_lvl & ~sclk_d1_q;
    wire sclk_f = ~sclk_lvl & sclk_d1_q;
    wire cs_lo = ~cs_s_q[1];

    //==========================================================================
    // Sleep control
    //==========================================================================
    // The level counter restarts on every sclk edge, so any burst at 10 kHz
    // or faster can never reach the entry count while a word is read.
    logic [LVL_CNT_W-1:0] lvl_cnt_q;
    logic asleep_q;

    wire lvl_sat = lvl_cnt_q == {LVL_CNT_W{1'b1}};
    wire slp_hit = ~asleep_q & sclk_lvl
                   & (lvl_cnt_q == LVL_CNT_W'(SLP_CYC - 1)); // [RQ1]
    wire wake_hit = asleep_q & ~sclk_lvl
                    & (lvl_cnt_q == LVL_CNT_W'(WAKE_CYC - 1)); // [RQ2]

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            lvl_cnt_q <= '0;
        end else if (sclk_r | sclk_f) begin
            lvl_cnt_q <= '0;
        end else if (!lvl_sat) begin
            lvl_cnt_q <= lvl_cnt_q + LVL_CNT_W'(1);
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            asleep_q <= 1'b0;
        end else if (slp_hit) begin
            asleep_q <= 1'b1; // [RQ1]
        end else if (wake_hit) begin
            asleep_q <= 1'b0; // [RQ2]
        end
    end

    //==========================================================================
    // Conversion pacing
    //==========================================================================
    logic [OSC_DIV_W-1:0] div_q;
    logic [CONV_CNT_W-1:0] conv_q;

    wire osc_tick = div_q == OSC_DIV_W'(OSC_DIV - 1); // [RQ5]
    // In the oscillator variant sclk reaches the pacing logic only through sleep.
    wire conv_tick = EXT_CLK ? sclk_r : osc_tick; // [RQ6] [RQ8]
    wire conv_last = conv_q == CONV_CNT_W'(CONV_TICKS - 1);
    wire conv_end = ~asleep_q & conv_tick & conv_last; // [RQ9]
    wire warn = ~EXT_CLK & (conv_q >= CONV_CNT_W'(CONV_TICKS - WARN_TICKS));

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            div_q <= '0;
        end else if (asleep_q || osc_tick) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + OSC_DIV_W'(1);
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            conv_q <= '0;
        end else if (asleep_q) begin
            conv_q <= '0; // [RQ18]
        end else if (conv_tick) begin
            conv_q <= conv_last ? '0 : conv_q + CONV_CNT_W'(1);
        end
    end

    //==========================================================================
    // Output word and shift-out
    //==========================================================================
    logic [WORD_W-1:0] sh_q;
    logic have_q;
    logic rd_q;
    logic arm_q;
    logic [BIT_CNT_W-1:0] bit_q;

    // The result goes out as delivered: any offset or gain fix is the host's.
    wire [FIELD_W-1:0] res_field = FIELD_W'(sample_i); // [RQ12] [RQ13]
    wire [WORD_W-1:0] new_word = {1'b0, ovr_i, osc_det_i, 1'b0, res_field}; // [RQ16]

    wire load = conv_end & ~rd_q;
    wire lost = conv_end & rd_q; // [RQ17]
    // The external variant lets one falling edge pass after ready, which
    // stretches the first bit to one and a half sclk cycles.
    wire arm_set = EXT_CLK & sclk_f & cs_lo & have_q & ~rd_q;
    wire rd_start = sclk_r & cs_lo & have_q & ~rd_q & ~warn & (~EXT_CLK | arm_q);
    wire rd_shift = sclk_f & rd_q; // [RQ15]
    wire rd_last = rd_shift & (bit_q == BIT_CNT_W'(WORD_W - 1));
    wire rd_abort = rd_q & ~cs_lo;

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            have_q <= 1'b0;
        end else if (asleep_q) begin
            have_q <= 1'b0; // [RQ18]
        end else if (load) begin
            have_q <= 1'b1;
        end else if (rd_last || rd_abort) begin
            have_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rd_q <= 1'b0;
        end else if (asleep_q || rd_last || rd_abort) begin
            rd_q <= 1'b0;
        end else if (rd_start) begin
            rd_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            arm_q <= 1'b0;
        end else if (asleep_q || load || rd_start || !cs_lo) begin
            arm_q <= 1'b0;
        end else if (arm_set) begin
            arm_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            bit_q <= '0;
        end else if (rd_start) begin
            bit_q <= '0;
        end else if (rd_shift) begin
            bit_q <= bit_q + BIT_CNT_W'(1);
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sh_q <= '0;
        end else if (load) begin
            sh_q <= new_word;
        end else if (rd_shift) begin
            sh_q <= {sh_q[WORD_W-2:0], 1'b0}; // [RQ15]
        end
    end

    //==========================================================================
    // Pin drive and user-side status
    //==========================================================================
    // Ready shows as a low line; it lifts during the warning window so the
    // host sees a fresh falling edge when the replacement word lands.
    wire ready_lo = have_q & ~warn & ~asleep_q; // [RQ14] [RQ17] [RQ18]
    wire sdo_d = rd_q ? sh_q[WORD_W-1] : ~ready_lo;

    logic sdo_q;
    logic sdo_oe_n_q;
    logic asleep_o_q;
    logic done_q;
    logic lost_q;

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sdo_q <= 1'b1;
            sdo_oe_n_q <= 1'b1;
            asleep_o_q <= 1'b0;
            done_q <= 1'b0;
            lost_q <= 1'b0;
        end else begin
            sdo_q <= sdo_d;
            sdo_oe_n_q <= ~cs_lo; // [RQ10]
            asleep_o_q <= asleep_q;
            done_q <= conv_end;
            lost_q <= lost; // [RQ17]
        end
    end

    assign link.sdo_out = sdo_q;
    assign link.sdo_oe_n = sdo_oe_n_q;
    assign asleep_o = asleep_o_q;
    assign conv_done_o = done_q;
    assign word_lost_o = lost_q;
endmodule : adsp_dev
`default_nettype wire

//--- design/adsp_host.sv
/*
 * Host end: reads 24-bit words over the link and drives sleep and wake.
 * Assumes the converter end on the far side of adsp_link_if and a
 * pull-up on the data line.
 */
`timescale 1ns/10ps
`default_nettype none
module adsp_host #(
    parameter bit EXT_CLK = 1'b0,
    parameter int HALF_CYC = adsp_pkg::HALF_CYC_DEF
) (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    adsp_link_if.host link,
    input wire logic read_req_i,
    input wire logic sleep_req_i,
    output logic [adsp_pkg::WORD_W-1:0] word_o,
    output logic word_valid_o,
    output logic busy_o
);
    import adsp_pkg::*;

    typedef enum logic [6:0] {
        H_IDLE = 7'h01,
        H_SETUP = 7'h02,
        H_WAIT = 7'h04,
        H_ARM = 7'h08,
        H_SHIFT = 7'h10,
        H_SLEEP = 7'h20,
        H_WAKE = 7'h40
    } adsp_hst_e;

    //==========================================================================
    // Data line synchroniser and serial clock generator
    //==========================================================================
    adsp_hst_e st_q, st_d;
    logic [1:0] sdo_s_q;
    logic [TM_W-1:0] hc_q;
    logic [TM_W-1:0] tm_q;
    logic [BIT_CNT_W-1:0] cnt_q;
    logic [WORD_W-1:0] rx_q;
    logic sclk_q;

    wire sdo_lo = ~sdo_s_q[1];
    wire parked = (st_q == H_SLEEP) | (st_q == H_WAKE);
    // Oscillator variant bursts only inside a read; idle stays low.
    wire run = EXT_CLK ? ~parked : (st_q == H_SHIFT); // [RQ3] [RQ4]
    wire tog = run & (hc_q == TM_W'(HALF_CYC - 1)); // [RQ7]
    wire rise = tog & ~sclk_q;
    wire fall = tog & sclk_q;
    wire rd_done = (st_q == H_SHIFT) & fall & (cnt_q == BIT_CNT_W'(WORD_W)); // [RQ15]

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sdo_s_q <= 2'h3;
            hc_q <= '0;
            sclk_q <= 1'b0;
        end else begin
            sdo_s_q <= {sdo_s_q[0], link.serial_data_out_pin};
            hc_q <= (!run || tog) ? '0 : hc_q + TM_W'(1);
            if (st_q == H_SLEEP) begin
                sclk_q <= 1'b1; // [RQ1]
            end else if (!run) begin
                sclk_q <= 1'b0; // [RQ2] [RQ4]
            end else if (tog) begin
                sclk_q <= ~sclk_q;
            end
        end
    end

    //==========================================================================
    // Read and sleep sequencer
    //==========================================================================
    always_comb begin
        st_d = st_q;
        case (st_q)
            H_IDLE: begin
                if (sleep_req_i) begin
                    st_d = H_SLEEP;
                end else if (read_req_i) begin
                    st_d = H_SETUP;
                end
            end
            H_SETUP: begin
                if (tm_q == TM_W'(CS_SETUP_CYC - 1)) begin
                    st_d = H_WAIT; // [RQ11]
                end
            end
            H_WAIT: begin
                if (sdo_lo) begin
                    st_d = EXT_CLK ? H_ARM : H_SHIFT; // [RQ14]
                end
            end
            H_ARM: begin
                if (fall) begin
                    st_d = H_SHIFT;
                end
            end
            H_SHIFT: begin
                if (rd_done) begin
                    st_d = H_IDLE;
                end
            end
            H_SLEEP: begin
                if (!sleep_req_i) begin
                    st_d = H_WAKE;
                end
            end
            H_WAKE: begin
                if (tm_q == TM_W'(WAKE_HOLD_CYC - 1)) begin
                    st_d = H_IDLE; // [RQ2]
                end
            end
            default: st_d = H_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_q <= H_IDLE;
            tm_q <= '0;
            cnt_q <= '0;
            rx_q <= '0;
        end else begin
            st_q <= st_d;
            tm_q <= (st_d != st_q) ? '0 : tm_q + TM_W'(1);
            if (st_q != H_SHIFT) begin
                cnt_q <= '0;
            end else if (rise) begin
                cnt_q <= cnt_q + BIT_CNT_W'(1);
                rx_q <= {rx_q[WORD_W-2:0], ~sdo_lo}; // [RQ15]
            end
        end
    end

    //==========================================================================
    // Outputs
    //==========================================================================
    logic cs_n_q;
    logic [WORD_W-1:0] word_q;
    logic valid_q;
    logic busy_q;

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cs_n_q <= 1'b1;
            word_q <= '0;
            valid_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            cs_n_q <= ~((st_d == H_SETUP) | (st_d == H_WAIT)
                        | (st_d == H_ARM) | (st_d == H_SHIFT));
            valid_q <= rd_done;
            busy_q <= st_d != H_IDLE;
            if (rd_done) begin
                word_q <= rx_q;
            end
        end
    end

    assign link.sclk = sclk_q;
    assign link.cs_n = cs_n_q;
    assign word_o = word_q;
    assign word_valid_o = valid_q;
    assign busy_o = busy_q;
endmodule : adsp_host
`default_nettype wire

//--- verification/adsp_link_chk.sv
/*
 * Checker for the three-wire link between the converter end and the host end.
 * Assumes the external-clock variant, one 20 MHz clock on both ends, and a
 * pull-up on the data line.
 */
`timescale 1ns/10ps
`default_nettype none
module adsp_link_chk
    import adsp_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdo_out,
    input wire logic sdo_oe_n,
    input wire logic serial_data_out_pin,
    input wire logic asleep_o,
    input wire logic conv_done_o,
    input wire logic word_valid_o,
    input wire logic busy_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (sys_rst_i);
    //==========================================================================
    // Helper counters
    // Run lengths saturate so that a long park never wraps into a false match.
    logic [15:0] hi_cnt_q;
    logic [15:0] lo_cnt_q;
    logic [9:0] rise_cnt_q;
    logic sclk_q;
    logic conv_seen_q;
    wire sclk_rise = sclk && !sclk_q;
    wire [15:0] hi_cnt_d = !sclk ? 16'h0000 : (&hi_cnt_q ? hi_cnt_q : hi_cnt_q + 16'h0001);
    wire [15:0] lo_cnt_d = sclk ? 16'h0000 : (&lo_cnt_q ? lo_cnt_q : lo_cnt_q + 16'h0001);
    wire [9:0] rise_cnt_d = (conv_done_o || asleep_o) ? 10'h000 : rise_cnt_q + {9'h000, sclk_rise};
    wire conv_seen_d = asleep_o ? 1'b0 : (conv_done_o || conv_seen_q);
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            hi_cnt_q <= 16'h0000;
            lo_cnt_q <= 16'h0000;
            rise_cnt_q <= 10'h000;
            sclk_q <= 1'b0;
            conv_seen_q <= 1'b0;
        end else begin
            hi_cnt_q <= hi_cnt_d;
            lo_cnt_q <= lo_cnt_d;
            rise_cnt_q <= rise_cnt_d;
            sclk_q <= sclk;
            conv_seen_q <= conv_seen_d;
        end
    end
    //==========================================================================
    // Assertions
    cs_release_a: assert property (
        $rose(cs_n) |-> ##[1:4] sdo_oe_n) else $error("data line driven after select rose");
    idle_release_a: assert property (
        cs_n [*5] |-> sdo_oe_n) else $error("data line driven while not selected");
    sleep_min_a: assert property (
        $rose(asleep_o) |-> hi_cnt_q >= SLP_CYC) else $error("sleep entered too early");
    sleep_bound_a: assert property (
        hi_cnt_q == SLP_CYC + 16 |-> asleep_o) else $error("sleep not entered");
    wake_min_a: assert property (
        $fell(asleep_o) |-> lo_cnt_q >= WAKE_CYC) else $error("wake too early");
    wake_bound_a: assert property (
        lo_cnt_q == WAKE_CYC + 16 |-> !asleep_o) else $error("wake not taken");
    sleep_quiet_a: assert property (
        asleep_o |-> !conv_done_o) else $error("conversion finished while asleep");
    bit_hold_a: assert property (
        $fell(sclk) && !cs_n && !$past(cs_n, 6) |-> $stable(serial_data_out_pin) [*3])
        else $error("data bit changed too soon after falling clock");
    valid_end_a: assert property (
        word_valid_o |-> ##[0:2] (cs_n && !busy_o)) else $error("read done without release");
    owr_period_a: assert property (
        conv_done_o && conv_seen_q |-> rise_cnt_q == CONV_TICKS)
        else $error("conversion length wrong");
    sleep_ready_a: assert property (
        asleep_o |-> sdo_out) else $error("ready shown while asleep");
    burst_rate_a: assert property (
        !cs_n |-> hi_cnt_q < CLK_KHZ / 10) else $error("serial clock high too long in a read");
    cover property (word_valid_o);
    cover property ($rose(asleep_o));
    cover property ($fell(asleep_o));
    cover property (conv_done_o && conv_seen_q);
endmodule : adsp_link_chk
`default_nettype wire

//--- verification/tb_adc_serial_read_sleep_port.sv
/*
 * Self-checking bench: the converter end and the host end face each other.
 * Assumes the external-clock variant, a 20-bit pair and a 16-bit pair run in
 * lockstep; each host makes its serial clock from the system clock.
 */
`timescale 1ns/10ps
`default_nettype none
module tb_adc_serial_read_sleep_port;
    import adsp_pkg::*;
    logic clk_sys_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [19:0] sample_i = 20'h00000;
    logic ovr_i = 1'b0;
    logic osc_det_i = 1'b0;
    logic read_req_i = 1'b0;
    logic sleep_req_i = 1'b0;
    logic [WORD_W-1:0] word_o;
    logic word_valid_o;
    logic busy_o;
    logic asleep_o;
    logic conv_done_o;
    logic word_lost_o;
    logic [WORD_W-1:0] word16_o;
    logic [31:0] lfsr_q = 32'h0000004A;
    int errors = 0;
    int comparisons = 0;
    int n;
    int k;
    int lost_n = 0;
    always #25 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) begin
        if (word_lost_o === 1'b1) begin
            lost_n <= lost_n + 1;
        end
    end
    //==========================================================================
    // Design and checker
    adsp_link_if link_if();
    adsp_dev #(.EXT_CLK(1'b1), .RES_W(20)) adsp_dev_inst (
        .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .link(link_if),
        .sample_i(sample_i), .ovr_i(ovr_i), .osc_det_i(osc_det_i),
        .asleep_o(asleep_o), .conv_done_o(conv_done_o), .word_lost_o(word_lost_o)
    );
    adsp_host #(.EXT_CLK(1'b1), .HALF_CYC(10)) adsp_host_inst (
        .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .link(link_if),
        .read_req_i(read_req_i), .sleep_req_i(sleep_req_i), .word_o(word_o),
        .word_valid_o(word_valid_o), .busy_o(busy_o)
    );
    // The 16-bit pair sees the same stimulus and keeps the same timing.
    adsp_link_if link16_if();
    adsp_dev #(.EXT_CLK(1'b1), .RES_W(16)) adsp_dev16_inst (
        .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .link(link16_if),
        .sample_i(sample_i[15:0]), .ovr_i(ovr_i), .osc_det_i(osc_det_i),
        .asleep_o(), .conv_done_o(), .word_lost_o()
    );
    adsp_host #(.EXT_CLK(1'b1), .HALF_CYC(10)) adsp_host16_inst (
        .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .link(link16_if),
        .read_req_i(read_req_i), .sleep_req_i(sleep_req_i), .word_o(word16_o),
        .word_valid_o(), .busy_o()
    );
    adsp_link_chk adsp_link_chk_inst (
        .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .sclk(link_if.sclk),
        .cs_n(link_if.cs_n), .sdo_out(link_if.sdo_out), .sdo_oe_n(link_if.sdo_oe_n),
        .serial_data_out_pin(link_if.serial_data_out_pin), .asleep_o(asleep_o), .conv_done_o(conv_done_o),
        .word_valid_o(word_valid_o), .busy_o(busy_o)
    );
    //==========================================================================
    // Helpers
    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr_next
    function automatic logic [23:0] exp_word(input logic [19:0] s, input logic o, input logic d);
        return {1'b0, o, d, 1'b0, s};
    endfunction : exp_word
    task automatic results();
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : results
    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic timed_out(input int i, input int lim);
        if (i >= lim) begin
            errors++;
            $display("BAD t=%0t count=%h limit=%h", $time, i, lim);
            results();
        end
    endtask : timed_out
    // The inputs are set before the conversion that feeds this read ends.
    task automatic read_word(input logic [19:0] s, input logic o, input logic d);
        int i;
        @(posedge clk_sys_i);
        sample_i <= s;
        ovr_i <= o;
        osc_det_i <= d;
        read_req_i <= 1'b1;
        i = 0;
        while (busy_o !== 1'b1 && i < 1000) begin
            @(negedge clk_sys_i);
            i++;
        end
        @(posedge clk_sys_i);
        read_req_i <= 1'b0;
        while (word_valid_o !== 1'b1 && i < 20000) begin
            @(negedge clk_sys_i);
            i++;
        end
        timed_out(i, 20000);
        repeat (6) @(negedge clk_sys_i);
        check(word_o, exp_word(s, o, d));
        check(word16_o, exp_word({4'h0, s[15:0]}, o, d));
        check({23'h000000, link_if.sdo_oe_n}, 24'h000001);
    endtask : read_word
    //==========================================================================
    // Main sequence
    initial begin
        repeat (3) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        read_word(20'h80000, 1'b1, 1'b0);
        read_word(20'h7FFFF, 1'b0, 1'b1);
        for (n = 0; n < 2; n++) begin
            lfsr_q = lfsr_next(lfsr_q);
            read_word(lfsr_q[19:0], lfsr_q[20], lfsr_q[21]);
        end
        // Leave a stale word pending so that the read after waking shows it was dropped.
        @(posedge clk_sys_i);
        sample_i <= 20'h12345;
        n = 0;
        while (conv_done_o !== 1'b1 && n < 14000) begin
            @(negedge clk_sys_i);
            n++;
        end
        timed_out(n, 14000);
        @(posedge clk_sys_i);
        sleep_req_i <= 1'b1;
        // Count only the unbroken high run on the pin, which may have begun already.
        n = 0;
        k = 0;
        while (asleep_o !== 1'b1 && k < 6000) begin
            @(negedge clk_sys_i);
            n = (link_if.sclk === 1'b1) ? n + 1 : 0;
            k++;
        end
        timed_out(k, 6000);
        check(24'(n >= SLP_CYC), 24'h000001);
        check(24'(n <= SLEEP_MAX_US * CLK_KHZ / 1000), 24'h000001);
        repeat (1000) @(negedge clk_sys_i);
        check({23'h000000, asleep_o}, 24'h000001);
        lfsr_q = lfsr_next(lfsr_q);
        @(posedge clk_sys_i);
        sample_i <= lfsr_q[19:0];
        sleep_req_i <= 1'b0;
        n = 0;
        k = 0;
        while (asleep_o !== 1'b0 && k < 1000) begin
            @(negedge clk_sys_i);
            n = (link_if.sclk === 1'b0) ? n + 1 : 0;
            k++;
        end
        timed_out(k, 1000);
        check(24'(n >= WAKE_CYC), 24'h000001);
        repeat (500) @(negedge clk_sys_i);
        read_word(lfsr_q[19:0], lfsr_q[22], lfsr_q[23]);
        check(24'(lost_n), 24'h000000);
        results();
    end
endmodule : tb_adc_serial_read_sleep_port
`default_nettype wire
